// ===== logic/usec_pkg.sv
package usec_pkg;

    // event codes
    localparam logic [7:0] EVT_SNP_LOCAL  = 8'h06;
    localparam logic [7:0] EVT_SNP_REMOTE = 8'h07;
    localparam logic [7:0] EVT_LLC_HIT    = 8'h08;
    localparam logic [7:0] EVT_LLC_MISS   = 8'h09;

    // unit masks for snoop response events
    localparam logic [7:0] UM_I_STATE     = 8'h01;
    localparam logic [7:0] UM_S_STATE     = 8'h02;
    localparam logic [7:0] UM_FWD_S       = 8'h04;
    localparam logic [7:0] UM_FWD_I       = 8'h08;
    localparam logic [7:0] UM_CONFLICT    = 8'h10;
    localparam logic [7:0] UM_WB          = 8'h20;
    localparam logic [7:0] UM_HIT_MODIFIED = 8'h24;

    // unit masks for llc hit and miss events
    localparam logic [7:0] UM_READ        = 8'h01;
    localparam logic [7:0] UM_WRITE       = 8'h02;
    localparam logic [7:0] UM_PROBE       = 8'h04;
    localparam logic [7:0] UM_ANY         = 8'h03;

    // widths and reset values
    localparam int         SNP_BITS_W     = 6;
    localparam int         LKP_BITS_W     = 3;
    localparam int         CNT_W_DEF      = 48;
    localparam logic [7:0] SEL_RESET      = 8'h00;

    typedef enum logic [2:0] {
        LS_I = 3'h0,
        LS_S = 3'h1,
        LS_E = 3'h2,
        LS_M = 3'h3,
        LS_F = 3'h4
    } usec_line_type;

    typedef enum logic [1:0] {
        SK_RD_CODE = 2'h0,
        SK_RD_DATA = 2'h1,
        SK_RD_INV  = 2'h2,
        SK_OTHER   = 2'h3
    } usec_snp_kind_type;

    typedef enum logic [2:0] {
        LC_RD_CODE            = 3'h0,
        LC_RD_DATA            = 3'h1,
        LC_READ_FOR_OWNERSHIP = 3'h2,
        LC_WB                 = 3'h3,
        LC_PRB_IOHUB          = 3'h4,
        LC_PRB_REM            = 3'h5,
        LC_OTHER              = 3'h6
    } usec_lkp_class_type;

endpackage : usec_pkg

// ===== logic/usec_snoop_class.sv
`timescale 1ns/1ps
module usec_snoop_class
    import usec_pkg::*;
(
    input  usec_snp_kind_type       i_kind,
    input  usec_line_type           i_state,
    input  logic                    i_conflict,
    output logic [SNP_BITS_W-1:0]   o_bits,
    output logic                    o_hit_modified,
    output usec_line_type           o_new_state,
    output logic                    o_fwd_valid,
    output usec_line_type           o_fwd_state
);

    logic is_read;

    always_comb begin
        is_read     = (i_kind == SK_RD_CODE) || (i_kind == SK_RD_DATA);
        o_bits      = '0;
        o_bits[0]   = (i_state == LS_I);
        // RQ2 shared state
        o_bits[1]   = (i_state == LS_S);
        o_bits[2]   = is_read && (i_state == LS_E);
        o_bits[3]   = (i_kind == SK_RD_INV) && (i_state == LS_M);
        // RQ5 conflict response
        o_bits[4]   = i_conflict;
        // RQ6 read hits modified
        o_bits[5]   = is_read && (i_state == LS_M);
        o_hit_modified = (i_state == LS_M) && (is_read || (i_kind == SK_RD_INV));
        o_new_state = i_state;
        o_fwd_valid = 1'b0;
        o_fwd_state = LS_I;
        // RQ3 demote exclusive, forward shared
        if (o_bits[2]) begin
            o_new_state = LS_S;
            o_fwd_valid = 1'b1;
            o_fwd_state = LS_S;
        end
        // RQ4 invalidate, forward modified
        if (o_bits[3]) begin
            o_new_state = LS_I;
            o_fwd_valid = 1'b1;
            o_fwd_state = LS_M;
        end
    end

endmodule : usec_snoop_class

// ===== logic/usec_lkp_class.sv
`timescale 1ns/1ps
module usec_lkp_class
    import usec_pkg::*;
(
    input  usec_lkp_class_type      i_class,
    input  logic                    i_hit,
    output logic [LKP_BITS_W-1:0]   o_hit_bits,
    output logic [LKP_BITS_W-1:0]   o_miss_bits
);

    logic [LKP_BITS_W-1:0] kind;
    logic                  hit_eff;

    always_comb begin
        kind    = '0;
        // RQ8 read class
        kind[0] = (i_class == LC_RD_CODE) || (i_class == LC_RD_DATA)
                  || (i_class == LC_READ_FOR_OWNERSHIP);
        kind[1] = (i_class == LC_WB);
        // RQ10 probe class
        kind[2] = (i_class == LC_PRB_IOHUB) || (i_class == LC_PRB_REM);
        // RQ9 inclusive cache, writebacks always hit
        hit_eff     = i_hit || kind[1];
        o_hit_bits  = hit_eff ? kind : '0;
        // RQ13 writeback miss never reported
        o_miss_bits = hit_eff ? '0 : kind;
    end

endmodule : usec_lkp_class

// ===== logic/usec_event_counter.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: 07H/01H counts remote snoop responses, line absent
// RQ2: umask 02H counts shared-state snoop responses
// RQ3: read snoop on exclusive demotes, forwards shared
// RQ4: read-invalidate on modified invalidates, forwards modified
// RQ5: umask 10H counts conflict snoop responses
// RQ6: umask 20H counts read snoops hitting modified
// RQ7: 07H/24H counts remote modified-hit responses
// RQ8: 08H/01H counts read and ownership hits
// RQ9: 08H/02H counts writeback hits; writebacks always hit
// RQ10: 08H/04H counts io_hub or remote probe hits
// RQ11: 08H/03H counts all read and write hits
// RQ12: 09H/01H counts read and ownership misses
// RQ13: 09H/02H writeback misses, always stays zero
// RQ14: 09H/04H counts io_hub or remote probe misses
// RQ15: 09H/03H counts all read and write misses
// RQ16: 06H/01H counts local snoop responses, line absent
// RQ17: count one per matching occurrence only
module usec_event_counter
    import usec_pkg::*;
#(
    parameter int CNT_W = CNT_W_DEF
)(
    input  logic                    i_sys_clk,
    input  logic                    i_rst_n,
    input  logic [7:0]              i_evt_code,
    input  logic [7:0]              i_umask,
    input  logic                    i_cnt_enable,
    input  logic                    i_cnt_clear,
    input  logic                    i_snp_valid,
    input  logic                    i_snp_remote,
    input  usec_snp_kind_type       i_snp_kind,
    input  usec_line_type           i_snp_state,
    input  logic                    i_snp_conflict,
    input  logic                    i_lkp_valid,
    input  usec_lkp_class_type      i_lkp_class,
    input  logic                    i_lkp_hit,
    output logic [CNT_W-1:0]        o_count,
    output logic                    o_match,
    output logic                    o_resp_valid,
    output usec_line_type           o_new_state,
    output logic                    o_fwd_valid,
    output usec_line_type           o_fwd_state
);

    function automatic logic mask_hit(input logic [7:0] umask, input logic [7:0] bits);
        mask_hit = |(umask & bits);
    endfunction : mask_hit

    logic [SNP_BITS_W-1:0]  snp_bits;
    logic                   snp_hit_modified;
    usec_line_type          snp_new_state;
    logic                   snp_fwd_valid;
    usec_line_type          snp_fwd_state;
    logic [LKP_BITS_W-1:0]  lkp_hit_bits;
    logic [LKP_BITS_W-1:0]  lkp_miss_bits;

    logic                   snp_sel;
    logic                   snp_match;
    logic                   lkp_match;
    logic                   count_inc;

    logic [CNT_W-1:0]       count_ff;
    logic [CNT_W-1:0]       nxt_count;
    logic                   match_ff;
    logic                   nxt_match;
    logic                   resp_valid_ff;
    logic                   nxt_resp_valid;
    usec_line_type          new_state_ff;
    usec_line_type          nxt_new_state;
    logic                   fwd_valid_ff;
    logic                   nxt_fwd_valid;
    usec_line_type          fwd_state_ff;
    usec_line_type          nxt_fwd_state;

    usec_snoop_class u_snoop_class (
        .i_kind      (i_snp_kind),
        .i_state     (i_snp_state),
        .i_conflict  (i_snp_conflict),
        .o_bits      (snp_bits),
        .o_hit_modified (snp_hit_modified),
        .o_new_state (snp_new_state),
        .o_fwd_valid (snp_fwd_valid),
        .o_fwd_state (snp_fwd_state)
    );

    usec_lkp_class u_lkp_class (
        .i_class     (i_lkp_class),
        .i_hit       (i_lkp_hit),
        .o_hit_bits  (lkp_hit_bits),
        .o_miss_bits (lkp_miss_bits)
    );

    // event qualification
    always_comb begin
        // RQ16 local home selected by 06H
        snp_sel = i_snp_valid
                  && (((i_evt_code == EVT_SNP_LOCAL) && !i_snp_remote)
                  || ((i_evt_code == EVT_SNP_REMOTE) && i_snp_remote));
        // RQ7 modified-hit mask is exact
        if (i_umask == UM_HIT_MODIFIED) begin
            snp_match = snp_sel && snp_hit_modified;
        end else begin
            // RQ1 per-bit snoop mask match
            snp_match = snp_sel && mask_hit(i_umask, {2'h0, snp_bits});
        end
        lkp_match = 1'b0;
        // RQ11 hit class mask match
        if (i_lkp_valid && (i_evt_code == EVT_LLC_HIT)) begin
            lkp_match = mask_hit(i_umask, {5'h00, lkp_hit_bits});
        end
        // RQ12 read misses
        // RQ14 probe misses
        // RQ15 miss class mask match
        if (i_lkp_valid && (i_evt_code == EVT_LLC_MISS)) begin
            lkp_match = mask_hit(i_umask, {5'h00, lkp_miss_bits});
        end
        count_inc = i_cnt_enable && (snp_match || lkp_match);
    end

    // counter and response next values
    always_comb begin
        nxt_count      = count_ff;
        // RQ17 one increment per match
        if (i_cnt_clear) begin
            nxt_count = '0;
        end else if (count_inc) begin
            nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        nxt_match      = count_inc && !i_cnt_clear;
        nxt_resp_valid = i_snp_valid;
        nxt_new_state  = i_snp_valid ? snp_new_state : new_state_ff;
        nxt_fwd_valid  = i_snp_valid && snp_fwd_valid;
        nxt_fwd_state  = i_snp_valid ? snp_fwd_state : fwd_state_ff;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_ff      <= '0;
            match_ff      <= 1'b0;
            resp_valid_ff <= 1'b0;
            new_state_ff  <= LS_I;
            fwd_valid_ff  <= 1'b0;
            fwd_state_ff  <= LS_I;
        end else begin
            count_ff      <= nxt_count;
            match_ff      <= nxt_match;
            resp_valid_ff <= nxt_resp_valid;
            new_state_ff  <= nxt_new_state;
            fwd_valid_ff  <= nxt_fwd_valid;
            fwd_state_ff  <= nxt_fwd_state;
        end
    end

    assign o_count      = count_ff;
    assign o_match      = match_ff;
    assign o_resp_valid = resp_valid_ff;
    assign o_new_state  = new_state_ff;
    assign o_fwd_valid  = fwd_valid_ff;
    assign o_fwd_state  = fwd_state_ff;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic quiet;
    logic lkp_quiet;
    assign quiet = i_cnt_enable && !i_cnt_clear && !i_lkp_valid;
    assign lkp_quiet = i_cnt_enable && !i_cnt_clear && !i_snp_valid;

    a_remote_miss_cnt: assert property ( // RQ1
        (quiet && i_snp_valid && i_snp_remote && (i_evt_code == EVT_SNP_REMOTE)
         && (i_umask == UM_I_STATE) && (i_snp_state == LS_I))
        |=> (o_count == $past(o_count) + 1) && o_match)
        else $error("remote absent-line response not counted");

    a_local_miss_cnt: assert property ( // RQ16
        (quiet && i_snp_valid && !i_snp_remote && (i_evt_code == EVT_SNP_LOCAL)
         && (i_umask == UM_I_STATE) && (i_snp_state == LS_I))
        |=> (o_count == $past(o_count) + 1))
        else $error("local absent-line response not counted");

    a_wrong_home_hold: assert property ( // RQ16
        (i_snp_valid && i_snp_remote && (i_evt_code == EVT_SNP_LOCAL)
         && !i_lkp_valid && !i_cnt_clear)
        |=> $stable(o_count) && !o_match)
        else $error("remote response counted under local event");

    a_shared_cnt: assert property ( // RQ2
        (quiet && i_snp_valid && (i_evt_code == EVT_SNP_REMOTE) && i_snp_remote
         && (i_umask == UM_S_STATE) && (i_snp_state == LS_S))
        |=> (o_count == $past(o_count) + 1))
        else $error("shared-state response not counted");

    a_excl_demote: assert property ( // RQ3
        (i_snp_valid && (i_snp_kind inside {SK_RD_CODE, SK_RD_DATA})
         && (i_snp_state == LS_E))
        |=> o_resp_valid && o_fwd_valid && (o_new_state == LS_S) && (o_fwd_state == LS_S))
        else $error("exclusive line not demoted to shared");

    a_mod_invalidate: assert property ( // RQ4
        (i_snp_valid && (i_snp_kind == SK_RD_INV) && (i_snp_state == LS_M))
        |=> o_fwd_valid && (o_new_state == LS_I) && (o_fwd_state == LS_M))
        else $error("modified line not invalidated and forwarded");

    a_conflict_cnt: assert property ( // RQ5
        (quiet && i_snp_valid && !i_snp_remote && (i_evt_code == EVT_SNP_LOCAL)
         && (i_umask == UM_CONFLICT) && i_snp_conflict)
        |=> (o_count == $past(o_count) + 1))
        else $error("conflict response not counted");

    a_hit_modified_cnt: assert property ( // RQ7
        (quiet && i_snp_valid && i_snp_remote && (i_evt_code == EVT_SNP_REMOTE)
         && (i_umask == UM_HIT_MODIFIED) && (i_snp_state == LS_E))
        |=> $stable(o_count))
        else $error("non-modified hit counted as modified hit");

    a_read_hit_cnt: assert property ( // RQ8
        (i_cnt_enable && !i_cnt_clear && !i_snp_valid && i_lkp_valid && i_lkp_hit
         && (i_lkp_class == LC_READ_FOR_OWNERSHIP) && (i_evt_code == EVT_LLC_HIT)
         && (i_umask == UM_READ))
        |=> (o_count == $past(o_count) + 1))
        else $error("ownership read hit not counted");

    a_wb_miss_zero: assert property ( // RQ13
        (i_lkp_valid && (i_lkp_class == LC_WB) && (i_evt_code == EVT_LLC_MISS)
         && !i_snp_valid && !i_cnt_clear)
        |=> $stable(o_count))
        else $error("writeback counted as a miss");

    a_probe_miss_cnt: assert property ( // RQ14
        (i_cnt_enable && !i_cnt_clear && !i_snp_valid && i_lkp_valid && !i_lkp_hit
         && (i_lkp_class == LC_PRB_IOHUB) && (i_evt_code == EVT_LLC_MISS)
         && (i_umask == UM_PROBE))
        |=> (o_count == $past(o_count) + 1))
        else $error("io_hub probe miss not counted");

    a_idle_stable: assert property ( // RQ17
        (!i_snp_valid && !i_lkp_valid && !i_cnt_clear) [*2]
        |=> $stable(o_count) && !o_match)
        else $error("count moved with no occurrence");

    a_read_mod_cnt: assert property ( // RQ6
        (quiet && i_snp_valid && !i_snp_remote && (i_evt_code == EVT_SNP_LOCAL)
         && (i_umask == UM_WB) && (i_snp_kind == SK_RD_DATA) && (i_snp_state == LS_M))
        |=> (o_count == $past(o_count) + 1))
        else $error("read snoop on modified line not counted");

    a_remote_mod_hit: assert property ( // RQ7
        (quiet && i_snp_valid && i_snp_remote && (i_evt_code == EVT_SNP_REMOTE)
         && (i_umask == UM_HIT_MODIFIED) && (i_snp_kind == SK_RD_INV) && (i_snp_state == LS_M))
        |=> (o_count == $past(o_count) + 1) && o_match)
        else $error("remote modified-hit response not counted");

    a_wb_hit_cnt: assert property ( // RQ9
        (lkp_quiet && i_lkp_valid && (i_lkp_class == LC_WB)
         && (i_evt_code == EVT_LLC_HIT) && (i_umask == UM_WRITE))
        |=> (o_count == $past(o_count) + 1) && o_match)
        else $error("writeback lookup not counted as a hit");

    a_probe_hit_cnt: assert property ( // RQ10
        (lkp_quiet && i_lkp_valid && i_lkp_hit && (i_lkp_class == LC_PRB_REM)
         && (i_evt_code == EVT_LLC_HIT) && (i_umask == UM_PROBE))
        |=> (o_count == $past(o_count) + 1))
        else $error("remote probe hit not counted");

    a_any_hit_cnt: assert property ( // RQ11
        (lkp_quiet && i_lkp_valid && i_lkp_hit && (i_lkp_class == LC_RD_CODE)
         && (i_evt_code == EVT_LLC_HIT) && (i_umask == UM_ANY))
        |=> (o_count == $past(o_count) + 1))
        else $error("read hit not counted under any-hit mask");

    a_read_miss_cnt: assert property ( // RQ12
        (lkp_quiet && i_lkp_valid && !i_lkp_hit && (i_lkp_class == LC_RD_DATA)
         && (i_evt_code == EVT_LLC_MISS) && (i_umask == UM_READ))
        |=> (o_count == $past(o_count) + 1))
        else $error("data read miss not counted");

    a_any_miss_cnt: assert property ( // RQ15
        (lkp_quiet && i_lkp_valid && !i_lkp_hit && (i_lkp_class == LC_RD_CODE)
         && (i_evt_code == EVT_LLC_MISS) && (i_umask == UM_ANY))
        |=> (o_count == $past(o_count) + 1) && o_match)
        else $error("read miss not counted under any-miss mask");

    a_any_miss_probe: assert property ( // RQ15
        (lkp_quiet && i_lkp_valid && (i_lkp_class == LC_PRB_IOHUB)
         && (i_evt_code == EVT_LLC_MISS) && (i_umask == UM_ANY))
        |=> $stable(o_count) && !o_match)
        else $error("probe counted under any-miss mask");

    a_disabled_hold: assert property ( // RQ17
        (!i_cnt_enable && !i_cnt_clear)
        |=> $stable(o_count) && !o_match)
        else $error("count moved while disabled");

    a_clear_zero: assert property ( // RQ17
        i_cnt_clear
        |=> (o_count == '0) && !o_match)
        else $error("count not cleared");

    c_remote_mod_hit: cover property (
        i_snp_valid && i_snp_remote && (i_umask == UM_HIT_MODIFIED) ##1 o_match);
    c_excl_demote: cover property (o_fwd_valid && (o_fwd_state == LS_S));
    c_any_miss: cover property (
        i_lkp_valid && (i_evt_code == EVT_LLC_MISS) && (i_umask == UM_ANY) ##1 o_match);
    c_wb_hit: cover property (
        i_lkp_valid && (i_lkp_class == LC_WB) && (i_evt_code == EVT_LLC_HIT) ##1 o_match);
    c_clear_after_count: cover property (
        o_match ##1 i_cnt_clear ##1 (o_count == '0));

endmodule : usec_event_counter

// ===== sim/usec_llc_model.sv
`timescale 1ns/1ps
module usec_llc_model
    import usec_pkg::*;
(
    input  wire logic          i_sys_clk,
    output usec_snp_kind_type  o_snp_kind,
    output usec_line_type      o_snp_state,
    output usec_lkp_class_type o_lkp_class,
    output logic               o_snp_valid,
    output logic               o_snp_remote,
    output logic               o_snp_conflict,
    output logic               o_lkp_valid,
    output logic               o_lkp_hit
);
    initial begin
        o_snp_valid = 1'b0;
        o_lkp_valid = 1'b0;
        o_snp_remote = 1'b0;
        o_snp_conflict = 1'b0;
        o_lkp_hit = 1'b0;
        o_snp_kind = SK_OTHER;
        o_snp_state = LS_I;
        o_lkp_class = LC_OTHER;
    end

    // n back-to-back pulses, then released fields scrambled
    task automatic xfer(input logic sv, input logic r, input usec_snp_kind_type k,
        input usec_line_type s, input logic c, input logic lv,
        input usec_lkp_class_type cl, input logic h, input int n);
        @(posedge i_sys_clk);
        #1;
        o_snp_valid = sv;
        o_snp_remote = r;
        o_snp_kind = k;
        o_snp_state = s;
        o_snp_conflict = c;
        o_lkp_valid = lv;
        o_lkp_class = cl;
        o_lkp_hit = h;
        repeat (n) @(posedge i_sys_clk);
        #1;
        o_snp_valid = 1'b0;
        o_lkp_valid = 1'b0;
        o_snp_remote = ~r;
        o_snp_kind = usec_snp_kind_type'(~k);
        o_snp_state = usec_line_type'(3'h3 ^ s);
        o_snp_conflict = ~c;
        o_lkp_class = usec_lkp_class_type'(3'h1 ^ cl);
        o_lkp_hit = ~h;
    endtask : xfer
endmodule : usec_llc_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
    import usec_pkg::*;
    localparam int CW = 16;
    logic               sys_clk;
    logic               rst_n;
    logic [7:0]         evt;
    logic [7:0]         um;
    logic               en;
    logic               clr;
    logic               sv, sr, sc, lv, lh;
    usec_snp_kind_type  sk;
    usec_line_type      ss, ns, fs;
    usec_lkp_class_type lc;
    logic [CW-1:0]      count;
    logic [CW-1:0]      exp_cnt;
    logic               match, rv, fv;
    int                 mismatches = 0;
    int                 total_checks = 0;
    int                 cycles = 0;

    usec_llc_model llc (.i_sys_clk(sys_clk), .o_snp_kind(sk), .o_snp_state(ss),
        .o_lkp_class(lc), .o_snp_valid(sv), .o_snp_remote(sr), .o_snp_conflict(sc),
        .o_lkp_valid(lv), .o_lkp_hit(lh));

    usec_event_counter #(.CNT_W(CW)) uut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
        .i_evt_code(evt), .i_umask(um), .i_cnt_enable(en), .i_cnt_clear(clr),
        .i_snp_valid(sv), .i_snp_remote(sr), .i_snp_kind(sk), .i_snp_state(ss),
        .i_snp_conflict(sc), .i_lkp_valid(lv), .i_lkp_class(lc), .i_lkp_hit(lh),
        .o_count(count), .o_match(match), .o_resp_valid(rv), .o_new_state(ns),
        .o_fwd_valid(fv), .o_fwd_state(fs));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("mismatches %0d checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            end_of_test();
        end
    end

    function automatic logic snp_exp(logic r, usec_snp_kind_type k, usec_line_type s, logic c);
        logic rd;
        rd = k inside {SK_RD_CODE, SK_RD_DATA};
        if (evt != (r ? 8'h07 : 8'h06)) return 1'b0;
        if (um == 8'h24) return s == LS_M && (rd || k == SK_RD_INV);
        return (um[0] && s == LS_I) || (um[1] && s == LS_S) || (um[2] && rd && s == LS_E)
            || (um[3] && k == SK_RD_INV && s == LS_M) || (um[4] && c)
            || (um[5] && rd && s == LS_M);
    endfunction : snp_exp

    function automatic logic lkp_exp(usec_lkp_class_type cl, logic h);
        logic eh;
        logic b;
        eh = (cl == LC_WB) ? 1'b1 : h;
        b = (um[0] && cl inside {LC_RD_CODE, LC_RD_DATA, LC_READ_FOR_OWNERSHIP})
            || (um[1] && cl == LC_WB) || (um[2] && cl inside {LC_PRB_IOHUB, LC_PRB_REM});
        return b && ((evt == 8'h08 && eh) || (evt == 8'h09 && !eh));
    endfunction : lkp_exp

    // one transfer, count tracked against expectation
    task automatic send(input logic s_v, input logic r, input usec_snp_kind_type k,
        input usec_line_type s, input logic c, input logic l_v,
        input usec_lkp_class_type cl, input logic h, input int n, output logic m);
        m = en && !clr && ((s_v && snp_exp(r, k, s, c)) || (l_v && lkp_exp(cl, h)));
        llc.xfer(s_v, r, k, s, c, l_v, cl, h, n);
        exp_cnt = clr ? '0 : exp_cnt + (m ? CW'(n) : '0);
        `CHK(count, exp_cnt)
    endtask : send

    task automatic t_snoop_table();
        logic [7:0] ums[6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
        logic m;
        usec_snp_kind_type k;
        usec_line_type s;
        for (int e = 5; e < 8; e++) begin
            foreach (ums[u]) begin
                evt = 8'(e);
                um = ums[u];
                for (int i = 0; i < 64; i++) begin
                    k = usec_snp_kind_type'(i[1:0]);
                    s = usec_line_type'({1'b0, i[3:2]});
                    send(1'b1, i[4], k, s, i[5], 1'b0, LC_OTHER, 1'b0, 1, m);
                    `CHK(match, m)
                    `CHK(rv, 1'b1)
                    if (s == LS_E && k inside {SK_RD_CODE, SK_RD_DATA}) begin
                        `CHK({fv, ns, fs}, {1'b1, LS_S, LS_S})
                    end
                    if (s == LS_M && k == SK_RD_INV) begin
                        `CHK({fv, ns, fs}, {1'b1, LS_I, LS_M})
                    end
                end
            end
        end
    endtask : t_snoop_table

    task automatic t_mod_hit();
        logic m;
        evt = 8'h07;
        um = 8'h24;
        for (int i = 0; i < 32; i++) begin
            send(1'b1, i[4], usec_snp_kind_type'(i[1:0]), usec_line_type'({1'b0, i[3:2]}),
                1'b0, 1'b0, LC_OTHER, 1'b0, 1, m);
            `CHK(match, m)
        end
    endtask : t_mod_hit

    task automatic t_lookup_table();
        logic [7:0] ums[4] = '{8'h01, 8'h02, 8'h04, 8'h03};
        logic m;
        for (int e = 8; e < 10; e++) begin
            foreach (ums[u]) begin
                evt = 8'(e);
                um = ums[u];
                for (int i = 0; i < 14; i++) begin
                    send(1'b0, 1'b0, SK_OTHER, LS_I, 1'b0, 1'b1,
                        usec_lkp_class_type'(3'(i / 2)), i[0], 1, m);
                    `CHK(match, m)
                    `CHK({rv, fv}, 2'h0)
                end
            end
        end
    endtask : t_lookup_table

    task automatic t_refusals();
        logic m;
        evt = 8'h07;
        um = 8'h01;
        en = 1'b0;
        send(1'b1, 1'b1, SK_RD_DATA, LS_I, 1'b0, 1'b0, LC_OTHER, 1'b0, 1, m);
        `CHK(match, 1'b0)
        en = 1'b1;
        send(1'b1, 1'b1, SK_RD_DATA, LS_I, 1'b0, 1'b0, LC_OTHER, 1'b0, 5, m);
        `CHK(match, 1'b1)
        clr = 1'b1;
        send(1'b1, 1'b1, SK_RD_DATA, LS_I, 1'b0, 1'b0, LC_OTHER, 1'b0, 1, m);
        `CHK(match, 1'b0)
        clr = 1'b0;
        evt = 8'h08;
        um = 8'h03;
        send(1'b1, 1'b1, SK_RD_DATA, LS_I, 1'b0, 1'b1, LC_RD_DATA, 1'b1, 3, m);
        `CHK(match, 1'b1)
    endtask : t_refusals

    initial begin
        rst_n = 1'b0;
        evt = 8'h00;
        um = 8'h00;
        en = 1'b1;
        clr = 1'b0;
        exp_cnt = '0;
        repeat (8) @(posedge sys_clk);
        #1;
        `CHK({count, match, fv, fs}, {CW'(0), 1'b0, 1'b0, LS_I})
        rst_n = 1'b1;
        t_snoop_table();
        t_mod_hit();
        t_lookup_table();
        t_refusals();
        end_of_test();
    end
endmodule : testbench
